// File: src/mtx_pkg.sv
// Constants, field layout and states for the transmit command word decoder
package mtx_pkg;
   // ************************************************************
   // Command word layout: three bytes per transmit baud
   // ************************************************************
   localparam int         CMD_BYTES      = 3;
   localparam int         CMD_W          = 24;
   localparam int         FIFO_DEPTH     = 16;
   localparam int         FSK_SAMPLES    = 6;
   // Field positions within the 24-bit word (byte 0 in bits 7..0)
   localparam int         MODE_LSB       = 0;   // First byte bits 3..0
   localparam int         SIG_LSB        = 4;   // First byte bits 5..4
   localparam int         ANS_ORG_BIT    = 7;   // First byte bit 7
   localparam int         ATTEN_LSB      = 8;   // Second byte bits 4..0
   localparam int         SCRAM_BIT      = 13;  // Second byte bit 5
   localparam int         RATE_BIT       = 15;  // Second byte bit 7
   localparam int         RX_FLAG_BIT    = 16;  // Third byte bit 0
   localparam int         DATA_LSB       = 17;  // Third byte bits 6..1
   localparam int         TXEN_N_BIT     = 23;  // Third byte bit 7
   localparam logic [23:0] RSVD_MASK     = 24'h004040;
   // Transmit standards
   localparam logic [3:0] STD_OFF        = 4'h0;
   localparam logic [3:0] STD_V22BIS     = 4'h1;
   localparam logic [3:0] STD_V22        = 4'h2;
   localparam logic [3:0] STD_BELL_212_MODE       = 4'h3;
   localparam logic [3:0] STD_V23        = 4'h4;
   localparam logic [3:0] STD_V21        = 4'h5;
   localparam logic [3:0] STD_B103       = 4'h6;
   localparam logic [3:0] STD_DTMF       = 4'h7;
   // Signalling codes
   localparam logic [1:0] SIG_OFF        = 2'h0;
   localparam logic [1:0] SIG_550        = 2'h1;
   localparam logic [1:0] SIG_RSVD       = 2'h2;
   localparam logic [1:0] SIG_1800       = 2'h3;
   // Attenuation
   localparam logic [4:0] ATTEN_MAX_DB   = 5'h17;  // 23 dB
   localparam logic [4:0] ATTEN_RST      = 5'h18;  // First infinite code
   // ************************************************************
   // Timing at 20 MHz
   // ************************************************************
   localparam int         CLK_PERIOD_NS  = 50;
   localparam int         IRQ_NEG_NS     = 1000;
   localparam int         IRQ_NEG_CYC    = (IRQ_NEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Mailbox sequencer states
   typedef enum logic [1:0] {
      MTX_IDLE  = 2'b00,
      MTX_OFFER = 2'b01,
      MTX_NEG   = 2'b10,
      MTX_XFER  = 2'b11
   } mtx_state_t;
endpackage : mtx_pkg

// File: src/mtx_decoder.sv
// Mailbox front end, command FIFO and transmit command word decoder
`timescale 1ns/10ps
// Function
// RQ1 - Every word is exactly three mailbox bytes
// RQ2 - Commands come in, status goes out
// RQ3 - Processor serves one exchange per baud
// RQ4 - Transmit and receive words programmed independently
// RQ5 - First byte bits 3..0 pick standard
// RQ6 - First byte bits 5..4 pick guard tone
// RQ7 - Bit 7 picks answer or originate channel
// RQ8 - Attenuation 0 to 23 dB, 1 dB steps
// RQ9 - Codes 11000 to 11111 mean no output
// RQ10 - Reset forces infinite attenuation
// RQ11 - Second byte bit 5 enables scrambler
// RQ12 - Second byte bit 7 picks 600 bps
// RQ13 - Third byte bit 0 clear marks transmit
// RQ14 - Third byte bit 7 low enables transmit
// RQ15 - Symbol bits 4..1, width per standard
// RQ16 - One exchange per symbol in phase modes
// RQ17 - FSK carries six samples per exchange
// RQ18 - FSK sends bit 1 first, ascending
// RQ19 - DTMF code selects one of sixteen tones
// RQ20 - Processor writes zero to reserved bits
// RQ21 - All three bytes checked every baud
// RQ22 - Third byte bit 0 set marks receive
// RQ23 - Status read precedes command write
// RQ24 - Reserved mode or signalling disables transmitter

// ************************************************************
// Pin synchroniser: three stages, change taken when 2 and 3 agree
// ************************************************************
module mtx_sync #(parameter int W = 1, parameter logic [W-1:0] INIT = '0)
(
   input  wire logic         clock,     // System clock
   input  wire logic         rst_n,     // Synchronous-released reset
   input  wire logic [W-1:0] pin,       // Asynchronous pin
   output logic      [W-1:0] stable     // Filtered level
);
   logic [W-1:0] s1_r, s2_r, s3_r;
   // First stage is read only by the second
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_r <= INIT;
         s2_r <= INIT;
         s3_r <= INIT;
      end
      else
      begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   // Update each bit only when two later stages agree, rejecting glitches
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         stable <= INIT;
      else
         stable <= (s2_r & ~(s2_r ^ s3_r)) | (stable & (s2_r ^ s3_r));
   end
endmodule : mtx_sync

// ************************************************************
// Command FIFO
// ************************************************************
module mtx_fifo #(parameter int WIDTH = 24, parameter int DEPTH = 16)
(
   input  wire logic             clock,      // System clock
   input  wire logic             rst_n,      // Reset, active low
   input  wire logic             in_valid,   // Word offered
   output logic                  in_ready,   // Room for a word
   input  wire logic [WIDTH-1:0] in_data,    // Word in
   output logic                  out_valid,  // Word available
   input  wire logic             out_ready,  // Consumer takes word
   output logic      [WIDTH-1:0] out_data    // Oldest word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_r, rd_r;
   logic [AW:0]      cnt_r;
   logic             push, pop;
   assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem[rd_r];
   // Storage
   always_ff @(posedge clock)
   begin
      if (push)
         mem[wr_r] <= in_data;
   end
   // Pointers and fill count
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
            wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
         if (pop)
            rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : mtx_fifo

// ************************************************************
// Top: mailbox sequencer and decoder
// ************************************************************
module mtx_decoder
(
   input  wire logic       clock,                   // 20 MHz clock
   input  wire logic       rstn,                    // Reset pin, active low
   input  wire logic [7:0] ad_in,                   // Data bus in
   output logic      [7:0] ad_out,                  // Data bus out
   output logic            ad_oe,                   // Data bus drive enable
   input  wire logic       sr_w,                    // High read, low write
   input  wire logic       sds_n,                   // Data strobe
   input  wire logic       cs_n,                    // Chip select
   input  wire logic       rs,                      // Register select
   output logic            irq_n,                   // Mailbox handshake
   input  wire logic       tx_baud_tick,            // Transmit baud pulse
   input  wire logic       fsk_tx_sample_clock,     // 7.2 kHz sample pulse
   output logic [3:0]      tx_standard,             // Active standard
   output logic [1:0]      guard_tone_sel,          // Signalling code
   output logic            answer_originate_select, // 1 originate, low channel
   output logic [4:0]      atten_db,                // Attenuation in dB
   output logic            atten_infinite,          // No transmit output
   output logic            scrambler_enable,        // Scrambler in path
   output logic            low_rate_600,            // V.22 at 600 bps
   output logic            dtmf_single_tone,        // DTMF single tone
   output logic            dtmf_low_tone,           // Single tone is low one
   output logic [3:0]      dtmf_code,               // Tone select
   output logic [3:0]      symbol_bits,             // Symbol data
   output logic [2:0]      symbol_width,            // Symbol bits in use
   output logic            first_tx_sample_bit,     // First FSK sample
   output logic            fsk_tx_bit,              // Serial FSK sample
   output logic            line_active,             // Transmitter drives line
   output logic            cmd_error                // Reserved bit set or reserved mode or signalling code
);
   import mtx_pkg::*;

   logic             rs1_r, rst_q;
   logic [11:0]      pins_s;
   logic             sds_q, sdsn_prev_r, strobe;
   logic [7:0]       din_s;
   logic             rw_s, cs_s, rs_s;
   mtx_state_t       state_r;
   logic [4:0]       neg_cnt_r;
   logic [2:0]       idx_r;
   logic [15:0]      cmd_lo_r;
   logic             dummy_r;
   logic             cmd_push, fifo_ready, fifo_valid, pop;
   logic [CMD_W-1:0] cmd_word, w;
   logic [5:0]       fsk_sh_r;
   logic             legal;
   logic             decoded_r;

   // ************************************************************
   // Reset release and pin synchronisers
   // ************************************************************
   // Two-flop release keeps reset removal clean
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         rs1_r <= 1'b0;
         rst_q <= 1'b0;
      end
      else
      begin
         rs1_r <= 1'b1;
         rst_q <= rs1_r;
      end
   end

   mtx_sync #(.W(12), .INIT(12'he00)) u_sync
   (
      .clock  (clock),
      .rst_n  (rst_q),
      .pin    ({cs_n, sds_n, sr_w, rs, ad_in}),
      .stable (pins_s)
   );
   assign cs_s  = pins_s[11];
   assign sds_q = pins_s[10];
   assign rw_s  = pins_s[9];
   assign rs_s  = pins_s[8];
   assign din_s = pins_s[7:0];

   // Strobe falling edge with chip selected marks one bus access
   always_ff @(posedge clock or negedge rst_q)
   begin
      if (!rst_q)
         sdsn_prev_r <= 1'b1;
      else
         sdsn_prev_r <= sds_q;
   end
   assign strobe = sdsn_prev_r & ~sds_q & ~cs_s;

   // ************************************************************
   // Mailbox sequencer
   // ************************************************************
   // Offer only when the FIFO has room, so a full FIFO stalls the processor
   always_ff @(posedge clock or negedge rst_q)
   begin
      if (!rst_q)
      begin
         state_r   <= MTX_IDLE;
         neg_cnt_r <= '0;
         idx_r     <= '0;
      end
      else
      begin
         unique case (state_r)
            MTX_IDLE:
               if (tx_baud_tick && fifo_ready)   // RQ3
                  state_r <= MTX_OFFER;
            MTX_OFFER:
               if (strobe && rw_s && !rs_s)
               begin
                  state_r   <= MTX_NEG;
                  neg_cnt_r <= 5'(IRQ_NEG_CYC - 1);
               end
            MTX_NEG:
               if (neg_cnt_r == '0)
               begin
                  state_r <= MTX_XFER;
                  idx_r   <= '0;
               end
               else
                  neg_cnt_r <= neg_cnt_r - 1'b1;
            MTX_XFER:
               if (strobe && rw_s && rs_s)
                  state_r <= MTX_IDLE;
               else if (strobe && idx_r < 3'h6)
               begin
                  // Three reads then three writes; out-of-order accesses are dropped
                  if ((idx_r < 3'h3) == rw_s)   // RQ23
                     idx_r <= idx_r + 1'b1;
               end
         endcase
      end
   end
   assign irq_n = (state_r != MTX_OFFER) && (state_r != MTX_NEG);

   // Status bytes out: byte 2 bit 0 clear marks a transmit status
   always_ff @(posedge clock or negedge rst_q)
   begin
      if (!rst_q)
         ad_out <= 8'h00;
      else if (strobe && rw_s && state_r == MTX_XFER)
      begin
         unique case (idx_r)
            3'h0:    ad_out <= {4'h0, tx_standard};   // RQ2
            3'h1:    ad_out <= {3'h0, atten_db};
            default: ad_out <= 8'h00;
         endcase
      end
   end
   assign ad_oe = (state_r == MTX_XFER) && !cs_s && rw_s && !sds_q && !rs_s;

   // Command bytes gathered; the first exchange after reset is a dummy
   always_ff @(posedge clock or negedge rst_q)
   begin
      if (!rst_q)
      begin
         cmd_lo_r <= '0;
         dummy_r  <= 1'b1;
      end
      else if (strobe && !rw_s && state_r == MTX_XFER)
      begin
         if (idx_r == 3'h3)
            cmd_lo_r[7:0] <= din_s;
         if (idx_r == 3'h4)
            cmd_lo_r[15:8] <= din_s;
         if (idx_r == 3'h5)
            dummy_r <= 1'b0;
      end
   end
   assign cmd_word = {din_s, cmd_lo_r};
   // Only a full three-byte transmit word is queued; receive words pass by
   assign cmd_push = strobe && !rw_s && state_r == MTX_XFER && idx_r == 3'h5
                     && !dummy_r && !din_s[0];   // RQ1 RQ13 RQ22

   mtx_fifo #(.WIDTH(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clock     (clock),
      .rst_n     (rst_q),
      .in_valid  (cmd_push),
      .in_ready  (fifo_ready),
      .in_data   (cmd_word),
      .out_valid (fifo_valid),
      .out_ready (tx_baud_tick),
      .out_data  (w)
   );
   assign pop = fifo_valid & tx_baud_tick;   // RQ16

   // ************************************************************
   // Decoder: whole word checked and applied once per baud
   // ************************************************************
   assign legal = !w[MODE_LSB+3] && (w[SIG_LSB +: 2] != SIG_RSVD);   // RQ24

   always_ff @(posedge clock or negedge rst_q)
   begin
      if (!rst_q)
      begin
         tx_standard             <= STD_OFF;
         guard_tone_sel          <= SIG_OFF;
         answer_originate_select <= 1'b0;
         atten_db                <= ATTEN_RST;
         atten_infinite          <= 1'b1;   // RQ10
         scrambler_enable        <= 1'b0;
         low_rate_600            <= 1'b0;
         dtmf_single_tone        <= 1'b0;
         dtmf_low_tone           <= 1'b0;
         dtmf_code               <= 4'h0;
         symbol_bits             <= 4'h0;
         symbol_width            <= 3'h0;
         first_tx_sample_bit     <= 1'b0;
         line_active             <= 1'b0;
         cmd_error               <= 1'b0;
         decoded_r               <= 1'b0;
      end
      else if (pop)   // RQ21
      begin
         decoded_r               <= 1'b1;
         tx_standard             <= legal ? w[MODE_LSB +: 4] : STD_OFF;   // RQ5
         guard_tone_sel          <= legal ? w[SIG_LSB +: 2] : SIG_OFF;    // RQ6
         answer_originate_select <= w[ANS_ORG_BIT] && w[MODE_LSB +: 4] != STD_DTMF;   // RQ7
         dtmf_low_tone           <= w[ANS_ORG_BIT] && w[MODE_LSB +: 4] == STD_DTMF;
         atten_db                <= w[ATTEN_LSB +: 5];   // RQ8
         atten_infinite          <= w[ATTEN_LSB +: 5] > ATTEN_MAX_DB;   // RQ9
         scrambler_enable        <= w[SCRAM_BIT];   // RQ11
         low_rate_600            <= w[RATE_BIT] && w[MODE_LSB +: 4] != STD_DTMF;   // RQ12
         dtmf_single_tone        <= w[RATE_BIT] && w[MODE_LSB +: 4] == STD_DTMF;
         dtmf_code               <= w[DATA_LSB +: 4];   // RQ19
         symbol_bits             <= w[DATA_LSB +: 4];   // RQ15
         first_tx_sample_bit     <= w[DATA_LSB];        // RQ17
         cmd_error               <= (w & RSVD_MASK) != '0 || !legal;   // RQ20
         line_active             <= legal && w[MODE_LSB +: 4] != STD_OFF
                                    && w[ATTEN_LSB +: 5] <= ATTEN_MAX_DB
                                    && !w[TXEN_N_BIT];   // RQ14
         unique case (w[MODE_LSB +: 4])
            STD_V22BIS: symbol_width <= 3'h4;   // RQ15
            STD_V22:    symbol_width <= w[RATE_BIT] ? 3'h1 : 3'h2;
            STD_BELL_212_MODE:   symbol_width <= 3'h2;
            default:    symbol_width <= 3'h0;
         endcase
      end
   end

   // FSK samples leave lowest bit first at the sample clock
   always_ff @(posedge clock or negedge rst_q)
   begin
      if (!rst_q)
         fsk_sh_r <= '0;
      else if (pop)
         fsk_sh_r <= w[DATA_LSB +: FSK_SAMPLES];   // RQ17
      else if (fsk_tx_sample_clock)
         fsk_sh_r <= {1'b0, fsk_sh_r[5:1]};   // RQ18
   end
   assign fsk_tx_bit = fsk_sh_r[0];

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_q);

   reset_atten_a: assert property (!decoded_r |-> atten_infinite && !line_active)  // RQ10
      else $error("attenuation not infinite before first command");
   atten_step_a: assert property (pop && w[ATTEN_LSB +: 5] <= ATTEN_MAX_DB  // RQ8
                                  |=> atten_db == $past(w[12:8]) && !atten_infinite)
      else $error("attenuation code not applied");
   atten_inf_a: assert property (pop && w[12:11] == 2'b11 |=> atten_infinite && !line_active)  // RQ9
      else $error("infinite attenuation code not honoured");
   rsvd_mode_a: assert property (pop && (w[3] || w[5:4] == SIG_RSVD)  // RQ24
                                 |=> tx_standard == STD_OFF && !line_active)
      else $error("reserved code did not disable transmitter");
   tx_enable_a: assert property (pop && w[TXEN_N_BIT] |=> !line_active)  // RQ14
      else $error("line driven with transmit enable high");
   // Second sample must follow the first pulse that arrives after a quiet gap
   fsk_order_a: assert property (pop ##1 (!fsk_tx_sample_clock && !pop) [*3]  // RQ18
                                 ##1 fsk_tx_sample_clock && !pop |=> fsk_tx_bit == $past(w[18], 5))
      else $error("FSK samples out of order");
   // Seen through the FIFO, so a broken push qualifier shows up
   rx_word_a: assert property (strobe && !rw_s && state_r == MTX_XFER && idx_r == 3'h5  // RQ22
                               && din_s[0] && !fifo_valid |=> !fifo_valid)
      else $error("receive word queued as transmit");
   scram_sel_a: assert property (pop |=> scrambler_enable == $past(w[SCRAM_BIT]))  // RQ11
      else $error("scrambler selection lost");
   sym_width_a: assert property (pop && w[3:0] == STD_V22 && w[RATE_BIT] |=> symbol_width == 3'h1)  // RQ15
      else $error("V.22 600 bps width wrong");
   irq_hold_a: assert property ($rose(state_r == MTX_NEG) |-> !irq_n [*8] ##1 !irq_n [*8] ##1 !irq_n [*4] ##1 irq_n)  // RQ23
      else $error("handshake negation timing wrong");

   dtmf_c:  cover property (pop && w[3:0] == STD_DTMF);
   fsk_c:   cover property (pop ##[1:20] fsk_tx_sample_clock);
   full_c:  cover property (!fifo_ready);
   xfer_c:  cover property (cmd_push ##[1:200] pop);
endmodule : mtx_decoder

// File: verification/mtx_cpu_model.sv
// Control processor model for the transmit mailbox
`timescale 1ns/10ps
// ************************************************************
// Processor side of the mailbox exchange
// ************************************************************
module mtx_cpu_model
(
   input  wire logic       clock,  // System clock
   input  wire logic       irq_n,  // Mailbox handshake
   input  wire logic [7:0] ad_rd,  // Resolved bus level
   output logic      [7:0] bus_d,  // Processor drive value
   output logic            sr_w,   // High read
   output logic            sds_n,  // Data strobe
   output logic            cs_n,   // Chip select
   output logic            rs      // Register select
);
   logic [7:0] status [3];         // Last status word read
   // Idle pins from time zero
   initial
   begin
      bus_d = 8'h5a;
      sr_w  = 1'b1;
      sds_n = 1'b1;
      cs_n  = 1'b1;
      rs    = 1'b0;
   end
   // One access; pins stand 8 cycles because the device filters them
   task automatic access(input logic rd, input logic sel, input logic [7:0] d, output logic [7:0] q);
      @(posedge clock);
      cs_n  <= 1'b0;
      rs    <= sel;
      sr_w  <= rd;
      bus_d <= rd ? ~bus_d : d;    // Released bus never shows a stale byte
      repeat (3) @(posedge clock);
      sds_n <= 1'b0;
      repeat (8) @(posedge clock);
      q = ad_rd;
      sds_n <= 1'b1;
      repeat (8) @(posedge clock);
      cs_n  <= 1'b1;
   endtask : access
   // Bounded wait for a handshake level
   task automatic wait_irq(input logic lvl, inout logic ok);
      int n;
      n = 0;
      while (irq_n !== lvl && n < 300)
      begin
         @(posedge clock);
         n++;
      end
      if (n >= 300)
         ok = 1'b0;
   endtask : wait_irq
   // Whole exchange; a slow processor waits gap cycles before answering
   task automatic exchange(input logic [23:0] w, input int gap, output logic ok);
      logic [7:0] q;
      ok = 1'b1;
      wait_irq(1'b0, ok);
      repeat (gap) @(posedge clock);
      access(1'b1, 1'b0, 8'h00, q);
      wait_irq(1'b1, ok);
      // Status first, then command, three bytes each
      for (int i = 0; i < 3; i++)
      begin
         access(1'b1, 1'b0, 8'h00, q);
         status[i] = q;
      end
      for (int i = 0; i < 3; i++)
         access(1'b0, 1'b0, w[8*i +: 8], q);
      access(1'b1, 1'b1, 8'h00, q);
   endtask : exchange
endmodule : mtx_cpu_model

// File: verification/tb_top.sv
// Self-checking bench for the transmit command word decoder
`timescale 1ns/10ps
// ************************************************************
// Bench top: reset, one exchange per baud, decode checks
// ************************************************************
module tb_top;
   import mtx_pkg::*;
   logic        clock    = 1'b0;
   logic        rstn     = 1'b0;
   logic        tick     = 1'b0;
   logic        fsk      = 1'b0;
   logic        dummy    = 1'b1;
   logic [31:0] seed     = 32'h95bf4cbf;
   logic [23:0] cur      = 24'h001800;  // Word whose decode must stand
   logic [23:0] w;
   int          fails    = 0;
   int          compares = 0;
   logic [7:0]  ad_out, bus_d;
   logic        ad_oe, sr_w, sds_n, cs_n, rs, irq_n, answer_originate_select, atten_infinite;
   logic        scrambler_enable, low_rate_600, first_tx_sample_bit, fsk_tx_bit, line_active, cmd_error;
   logic        dtmf_single_tone, dtmf_low_tone;
   logic [3:0]  tx_standard, dtmf_code, symbol_bits;
   logic [1:0]  guard_tone_sel;
   logic [4:0]  atten_db;
   logic [2:0]  symbol_width;
   logic [23:0] corner [9] = '{24'h001709, 24'h001721, 24'h001701, 24'h001801,
                               24'h001f01, 24'h010001, 24'h80a031, 24'h1e8f97, 24'h0a4042};
   wire  [7:0]  ad_wire = ad_oe ? ad_out : bus_d;  // Resolved data bus
   always #25 clock = ~clock;
   mtx_decoder uut
   (
      .clock, .rstn, .ad_in(ad_wire), .ad_out, .ad_oe, .sr_w, .sds_n, .cs_n, .rs, .irq_n,
      .tx_baud_tick(tick), .fsk_tx_sample_clock(fsk), .tx_standard, .guard_tone_sel,
      .answer_originate_select, .atten_db, .atten_infinite, .scrambler_enable, .low_rate_600,
      .dtmf_single_tone, .dtmf_low_tone, .dtmf_code, .symbol_bits, .symbol_width,
      .first_tx_sample_bit, .fsk_tx_bit, .line_active, .cmd_error
   );
   mtx_cpu_model cpu
   (
      .clock, .irq_n, .ad_rd(ad_wire), .bus_d, .sr_w, .sds_n, .cs_n, .rs
   );
   // Xorshift source with a fixed start so runs repeat
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // Standard and signalling codes both defined
   function automatic logic legal(input logic [23:0] c);
      return (c[3] == 1'b0) && (c[5:4] != SIG_RSVD);
   endfunction : legal
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One baud: pop, check the standing decode, then exchange the next word
   task automatic step(input logic [23:0] nw);
      logic ok;
      int   m;
      m = cur[3:0];
      @(posedge clock);
      tick <= 1'b1;
      @(posedge clock);
      tick <= 1'b0;
      repeat (3) @(posedge clock);
      chk("tx_standard", legal(cur) ? cur[3:0] : STD_OFF, tx_standard);
      chk("guard_tone_sel", legal(cur) ? cur[5:4] : SIG_OFF, guard_tone_sel);
      chk("atten_db", cur[12:8], atten_db);
      chk("atten_infinite", cur[12:11] == 2'b11, atten_infinite);
      chk("scrambler_enable", cur[13], scrambler_enable);
      chk("line_active", legal(cur) && m != 0 && cur[12:11] != 2'b11 && !cur[23], line_active);
      chk("cmd_error", !legal(cur) || (cur & RSVD_MASK) != 24'h000000, cmd_error);
      if (legal(cur) && m != 0 && m != 7)
      begin
         chk("answer_originate_select", cur[7], answer_originate_select);
         chk("low_rate_600", cur[15], low_rate_600);
      end
      if (legal(cur) && m == 7)
      begin
         chk("dtmf_code", cur[20:17], dtmf_code);
         chk("dtmf_single_tone", cur[15], dtmf_single_tone);
         chk("dtmf_low_tone", cur[7], dtmf_low_tone);
      end
      if (legal(cur) && m >= 1 && m <= 3)
      begin
         chk("symbol_bits", cur[20:17], symbol_bits);
         chk("symbol_width", (m == 1) ? 4 : (m == 2 && cur[15]) ? 1 : 2, symbol_width);
      end
      // Samples leave in ascending order, one per sample pulse
      if (legal(cur) && m >= 4 && m <= 6)
      begin
         chk("first_tx_sample_bit", cur[17], first_tx_sample_bit);
         for (int k = 0; k < 6; k++)
         begin
            chk("fsk_tx_bit", cur[17 + k], fsk_tx_bit);
            fsk <= 1'b1;
            @(posedge clock);
            fsk <= 1'b0;
            repeat (2) @(posedge clock);
         end
      end
      cpu.exchange(nw, (xs() % 6) * 4, ok);
      chk("handshake", 1'b1, ok);
      chk("status_byte0", {4'h0, legal(cur) ? cur[3:0] : STD_OFF}, cpu.status[0]);
      chk("status_byte1", {3'h0, cur[12:8]}, cpu.status[1]);
      chk("status_byte2", 8'h00, cpu.status[2]);
      if (nw[16] == 1'b0 && !dummy)
         cur = nw;
   endtask : step
   task automatic final_report();
      if (fails == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   // Main sequence: standard codes 0 to 7, corner words, then random words
   initial
   begin
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      repeat (6) @(posedge clock);
      chk("atten_db", ATTEN_RST, atten_db);
      chk("atten_infinite", 1'b1, atten_infinite);
      step(24'h000031);
      dummy = 1'b0;
      for (int i = 0; i < 41; i++)
      begin
         w = 24'(xs()) & 24'hfebfb7;
         if (i < 8)
            w[3:0] = 4'(i);
         else if (i < 17)
            w = corner[i - 8];
         step(w);
      end
      step(24'h001800);
      rstn <= 1'b0;
      repeat (3) @(posedge clock);
      chk("atten_db", ATTEN_RST, atten_db);
      final_report();
   end
   // Watchdog well beyond the expected run length
   initial
   begin
      repeat (30000) @(posedge clock);
      fails++;
      final_report();
   end
endmodule : tb_top
